// ### verification/lpi_link_sva.sv
// Checker for the link wires between the host and the device ends.
// Assumes the bench feeds it the interface signals and the system clock.
`timescale 1ns/1ps
module lpi_link_sva
   import lpi_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic link_ck,
   input wire logic chip_sel_b,
   input wire logic data_lines_h_oe,
   input wire logic data_lines_d_oe,
   input wire logic [DQ_W-1:0] data_lines_h,
   input wire logic [DQ_W-1:0] data_lines_d,
   input wire logic strobe_h_oe,
   input wire logic strobe_d_oe,
   input wire logic [LANES-1:0] data_strobe_p_h,
   input wire logic [LANES-1:0] data_strobe_p_d,
   input wire logic [LANES-1:0] data_strobe_n_d,
   input wire logic [LANES-1:0] write_byte_mask
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   // ==========================================================
   // Read drive length and strobe edge counters
   logic [4:0] drive_cnt_r;
   logic [2:0] edge_cnt_r;
   logic prev_p_r;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         drive_cnt_r <= 5'h00;
         edge_cnt_r <= 3'h0;
         prev_p_r <= 1'b0;
      end else begin
         prev_p_r <= data_strobe_p_d[0];
         drive_cnt_r <= data_lines_d_oe ? drive_cnt_r + 5'h01 : 5'h00;
         if (!data_lines_d_oe)
            edge_cnt_r <= 3'h0;
         else if (strobe_d_oe && data_strobe_p_d[0] != prev_p_r)
            edge_cnt_r <= edge_cnt_r + 3'h1;
      end
   end

   // ==========================================================
   // Assertions
   a_no_bus_contention: assert property (!(data_lines_d_oe && data_lines_h_oe))
      else $error("both ends drive the data lines");
   a_strobe_with_data: assert property (data_lines_d_oe == strobe_d_oe)
      else $error("read strobe enable differs from data enable");
   a_strobe_pair_diff: assert property (strobe_d_oe |-> data_strobe_n_d == ~data_strobe_p_d)
      else $error("read strobe pair not complementary");
   a_lanes_in_step: assert property (strobe_d_oe |->
         (data_strobe_p_d == 4'h0 || data_strobe_p_d == 4'hf))
      else $error("read strobe lanes out of step");
   a_read_edge_align: assert property (strobe_d_oe && $past(strobe_d_oe) &&
         $changed(data_strobe_p_d) |-> $changed(data_lines_d))
      else $error("read strobe edge without data change");
   a_write_centre: assert property (strobe_h_oe && $past(strobe_h_oe) &&
         $changed(data_strobe_p_h) |-> $stable(data_lines_h))
      else $error("write data moves on a strobe edge");
   a_read_drive_len: assert property ($fell(data_lines_d_oe) |-> drive_cnt_r == 5'h18)
      else $error("read drive length wrong");
   a_read_four_beats: assert property ($fell(data_lines_d_oe) |-> edge_cnt_r == 3'h4)
      else $error("read burst edge count wrong");
   a_cmd_one_cycle: assert property ($fell(chip_sel_b) |->
         !chip_sel_b [*4] ##1 chip_sel_b)
      else $error("chip select low for wrong span");
   a_cs_at_rise: assert property ($fell(chip_sel_b) |->
         !link_ck ##[1:4] ($rose(link_ck) && !chip_sel_b))
      else $error("chip select not low at rising link edge");

   // ==========================================================
   // Covers
   c_write: cover property ($rose(data_lines_h_oe));
   c_read: cover property ($rose(data_lines_d_oe));
   c_masked: cover property (data_lines_h_oe && write_byte_mask != 4'h0);
endmodule : lpi_link_sva

// ### verification/lpi_tb_top.sv
// Bench joining host and device ends; drives user sides and checks memory.
// Assumes the host makes the link clock from clk.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin failures++; \
   $display("unexpected %s expected %h seen %h", nm, ex, got); end end
module lpi_link_tb_top;
   import lpi_pkg::*;
   logic clk = 1'b0, rst_b = 1'b0, req_valid = 1'b0, req_ready, req_write = 1'b0;
   logic wr_valid = 1'b0, wr_ready, rd_valid, busy, cmd_seen;
   logic [ADDR_W-1:0] req_addr = 4'h0, peek_addr = 4'h0, cmd_addr;
   logic [DQ_W-1:0] wr_data = 32'h0, rd_data, peek_data;
   logic [LANES-1:0] wr_mask = 4'h0;
   logic [OP_W-1:0] cmd_op;
   logic [DQ_W-1:0] wdat [4], expw [4];
   logic [LANES-1:0] wmsk [4];
   int failures = 0, comparisons = 0;
   lpi_link_if lk();
   lpi_host_end u_lpi_host_end (.clk(clk), .rst_b(rst_b), .link(lk.host),
      .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
      .req_addr(req_addr), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
      .wr_mask(wr_mask), .rd_valid(rd_valid), .rd_data(rd_data));
   lpi_dev_end u_lpi_dev_end (.clk(clk), .rst_b(rst_b), .link(lk.device),
      .peek_addr(peek_addr), .peek_data(peek_data), .cmd_seen(cmd_seen),
      .cmd_op(cmd_op), .cmd_addr(cmd_addr), .busy(busy));
   lpi_link_sva u_lpi_link_sva (.clk(clk), .rst_b(rst_b), .link_ck(lk.link_ck),
      .chip_sel_b(lk.chip_sel_b), .data_lines_h_oe(lk.data_lines_h_oe),
      .data_lines_d_oe(lk.data_lines_d_oe), .data_lines_h(lk.data_lines_h),
      .data_lines_d(lk.data_lines_d), .strobe_h_oe(lk.strobe_h_oe),
      .strobe_d_oe(lk.strobe_d_oe), .data_strobe_p_h(lk.data_strobe_p_h),
      .data_strobe_p_d(lk.data_strobe_p_d), .data_strobe_n_d(lk.data_strobe_n_d),
      .write_byte_mask(lk.write_byte_mask));
   // ==========================================================
   // Clock and watchdog
   initial begin
      forever #10 clk = ~clk;
   end
   initial begin
      #200000;
      failures++;
      finish_test();
   end
   // ==========================================================
   // Access tasks
   task automatic issue(input logic wr, input logic [ADDR_W-1:0] a);
      @(posedge clk);
      req_valid <= 1'b1; req_write <= wr; req_addr <= a;
      @(negedge clk);
      while (req_ready !== 1'b1) @(negedge clk);
      @(posedge clk);
      req_valid <= 1'b0;
   endtask : issue
   task automatic push(input int first, input int last);
      @(posedge clk);
      for (int k = first; k <= last; k++) begin
         wr_valid <= 1'b1; wr_data <= wdat[k]; wr_mask <= wmsk[k];
         @(negedge clk);
         while (wr_ready !== 1'b1) @(negedge clk);
         @(posedge clk);
      end
      wr_valid <= 1'b0;
   endtask : push
   task automatic idle();
      @(negedge clk);
      while (req_ready !== 1'b1 || busy !== 1'b0) @(negedge clk);
   endtask : idle
   task automatic peek_all(input int t);
      for (int k = 0; k < 4; k++) begin
         @(posedge clk) peek_addr <= 4'he + k[3:0];
         repeat (2) @(posedge clk);
         @(negedge clk) `CHK("peek_data", expw[k], peek_data)
      end
      $display("test %0d done", t);
   endtask : peek_all
   task automatic finish_test();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : finish_test
   // ==========================================================
   // Tests
   initial begin
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      // Plain burst wrapping past the top word
      for (int k = 0; k < 4; k++) begin
         wdat[k] = 32'ha0a1a2a3 + 32'h11111111 * k; wmsk[k] = 4'h0; expw[k] = wdat[k];
      end
      fork issue(1'b1, 4'he); push(0, 3); join
      idle();
      `CHK("cmd_op", OP_WRITE, cmd_op)
      peek_all(1);
      // Masked burst, buffer filled to refusal first
      wmsk[0] = 4'h0; wmsk[1] = 4'h1; wmsk[2] = 4'h6; wmsk[3] = 4'h8;
      for (int k = 0; k < 4; k++) begin
         wdat[k] = 32'h5c5d5e5f ^ k;
         for (int i = 0; i < LANES; i++)
            if (!wmsk[k][i]) expw[k][8*i +: 8] = wdat[k][8*i +: 8];
      end
      push(0, 1);
      @(negedge clk) `CHK("wr_ready", 1'b0, wr_ready)
      fork issue(1'b1, 4'he); push(2, 3); join
      idle();
      peek_all(2);
      // Burst with an empty buffer stores nothing
      issue(1'b1, 4'he);
      idle();
      peek_all(3);
      // Read burst back
      fork
         issue(1'b0, 4'he);
         for (int k = 0; k < 4; k++) begin
            @(negedge clk);
            while (rd_valid !== 1'b1) @(negedge clk);
            `CHK("rd_data", expw[k], rd_data)
         end
      join
      idle();
      `CHK("cmd_op", OP_READ, cmd_op)
      `CHK("cmd_addr", 4'he, cmd_addr)
      $display("test 4 done");
      finish_test();
   end
endmodule : lpi_link_tb_top

// ### verilog/lpi_dev_end.sv
// Memory device end: command capture, masked burst writes, burst reads.
// Assumes the host makes the link clock; every link pin is sampled by clk.
//
// Notes on behaviour
// R1: Chip select sampled at rising link edge.
// R2: Command/address pins are device inputs only.
// R3: One 32-bit data bus, both directions.
// R4: Strobes driven by data's sender.
// R5: Read strobe edge-aligned; write strobe centred.
// R6: Strobe n times byte lane n.
// R7: Mask high at a beat blocks that byte.
// R8: Mask captured on both strobe edges.
// R9: Mask bit n governs byte lane n.
// R10: Device never drives the mask pins.
// R11: Command is one cycle, both edges.
// R12: Two beats per link cycle, four per burst.
// R13: Controller releases bus during reads.
`timescale 1ns/1ps
module lpi_dev_end (
   input wire logic clk,
   input wire logic rst_b,
   lpi_link_if.device link,
   input wire logic [lpi_pkg::ADDR_W-1:0] peek_addr,
   output logic [lpi_pkg::DQ_W-1:0] peek_data,
   output logic cmd_seen,
   output logic [lpi_pkg::OP_W-1:0] cmd_op,
   output logic [lpi_pkg::ADDR_W-1:0] cmd_addr,
   output logic busy
);
   import lpi_pkg::*;

   typedef enum logic [6:0] {
      D_IDLE = 7'h01,
      D_CMD = 7'h02,
      D_WR = 7'h04,
      D_RWAIT = 7'h08,
      D_RPRE = 7'h10,
      D_RBEAT = 7'h20,
      D_RPOST = 7'h40
   } lpi_dstate_type;

   lpi_dstate_type state_r;
   lpi_dstate_type state_nxt;
   logic ck_s1, ck_s2, ck_s3;
   logic cs_s1, cs_s2;
   logic [CA_W-1:0] ca_s1, ca_s2;
   logic [DQ_W-1:0] dq_s1, dq_s2;
   logic [LANES-1:0] dm_s1, dm_s2;
   logic [LANES-1:0] dqs_s1, dqs_s2, dqs_s3;
   logic [LANES-1:0] dqsn_s1, dqsn_s2;
   logic ck_rise, ck_fall, launch, dq_oe_r, cmd_seen_r, busy_r;
   logic [LANES-1:0] lane_edge, lane_done, dqs_r;
   logic [OP_W-1:0] op_r;
   logic [ADDR_W-1:0] base_r, rd_idx;
   logic [TMR_W-1:0] tmr_r;
   logic [1:0] beat_r;
   logic [DQ_W-1:0] rd_word, peek_word, dq_o_r, peek_r;

   // ==========================================================
   // Pin synchronisers
   // Two stages on every link input; mask pins are only ever read here
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ck_s1 <= 1'b0;
         ck_s2 <= 1'b0;
         ck_s3 <= 1'b0;
         cs_s1 <= 1'b1;
         cs_s2 <= 1'b1;
         ca_s1 <= '0;
         ca_s2 <= '0;
         dq_s1 <= '0;
         dq_s2 <= '0;
         dm_s1 <= '0;
         dm_s2 <= '0;
      end else begin
         ck_s1 <= link.link_ck;
         ck_s2 <= ck_s1;
         ck_s3 <= ck_s2;
         cs_s1 <= link.chip_sel_b;
         cs_s2 <= cs_s1;
         ca_s1 <= link.cmd_addr_bus; // R2
         ca_s2 <= ca_s1;
         dq_s1 <= link.data_lines;
         dq_s2 <= dq_s1;
         dm_s1 <= link.write_byte_mask; // R10
         dm_s2 <= dm_s1;
      end
   end

   // Strobe synchronisers, both legs
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         dqs_s1 <= '0;
         dqs_s2 <= '0;
         dqs_s3 <= '0;
         dqsn_s1 <= '1;
         dqsn_s2 <= '1;
      end else begin
         dqs_s1 <= link.data_strobe_p;
         dqs_s2 <= dqs_s1;
         dqs_s3 <= dqs_s2;
         dqsn_s1 <= link.data_strobe_n;
         dqsn_s2 <= dqsn_s1;
      end
   end

   // Link clock edges as seen after synchronising
   assign ck_rise = ck_s2 & ~ck_s3;
   assign ck_fall = ~ck_s2 & ck_s3;

   // Both strobe edges count, only while the pair is complementary
   assign lane_edge = (dqs_s2 ^ dqs_s3) & (dqs_s2 ^ dqsn_s2); // R8

   // ==========================================================
   // Command capture
   // First half with chip select at rise, address at fall
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         op_r <= '0;
         base_r <= '0;
         cmd_seen_r <= 1'b0;
      end else begin
         cmd_seen_r <= 1'b0;
         if (state_r == D_IDLE && ck_rise && !cs_s2) begin
            op_r <= ca_s2[OP_LSB +: OP_W]; // R1 R11
         end
         if (state_r == D_CMD && ck_fall) begin
            base_r <= ca_s2[ADDR_LSB +: ADDR_W]; // R11
            cmd_seen_r <= 1'b1;
         end
      end
   end

   // ==========================================================
   // Sequencer
   // Next state from link events and the beat timer
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         D_IDLE: begin
            if (ck_rise && !cs_s2) begin
               state_nxt = D_CMD; // R1
            end
         end
         D_CMD: begin
            if (ck_fall) begin
               if (op_r == OP_WRITE) begin
                  state_nxt = D_WR;
               end else if (op_r == OP_READ) begin
                  state_nxt = D_RWAIT;
               end else begin
                  state_nxt = D_IDLE;
               end
            end
         end
         D_WR: begin
            if (&lane_done) begin
               state_nxt = D_IDLE;
            end
         end
         D_RWAIT: begin
            if (tmr_r == '0) begin
               state_nxt = D_RPRE;
            end
         end
         D_RPRE: begin
            if (tmr_r == '0) begin
               state_nxt = D_RBEAT;
            end
         end
         D_RBEAT: begin
            if (tmr_r == '0 && beat_r == BEAT_LAST) begin
               state_nxt = D_RPOST;
            end
         end
         D_RPOST: begin
            if (tmr_r == '0) begin
               state_nxt = D_IDLE;
            end
         end
         default: begin
            state_nxt = D_IDLE;
         end
      endcase
   end

   // State register
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_r <= D_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Timer: read latency, then one half link period per beat
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         tmr_r <= '0;
      end else if (state_nxt == D_RWAIT && state_r != D_RWAIT) begin
         tmr_r <= TMR_W'(RD_GAP_CYC - 1);
      end else if ((state_nxt != state_r) || (state_r == D_RBEAT && tmr_r == '0)) begin
         tmr_r <= TMR_W'(CK_HALF_CYC - 1); // R12
      end else if (tmr_r != '0) begin
         tmr_r <= tmr_r - 1'b1;
      end
   end

   // Beat index within the read burst
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         beat_r <= '0;
      end else if (state_r != D_RBEAT) begin
         beat_r <= '0;
      end else if (tmr_r == '0) begin
         beat_r <= beat_r + 1'b1;
      end
   end

   // ==========================================================
   // Read drive
   // New beat starts at burst entry and at each timer expiry before the last beat
   assign launch = (state_nxt == D_RBEAT) && (state_r != D_RBEAT || tmr_r == '0);
   assign rd_idx = (state_r == D_RBEAT) ? ADDR_W'(base_r + ADDR_W'(beat_r) + 1'b1) : base_r;

   // Data and strobe change together, strobe toggles per beat
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         dq_o_r <= '0;
         dqs_r <= '0;
         dq_oe_r <= 1'b0;
      end else begin
         dq_oe_r <= (state_nxt == D_RPRE) || (state_nxt == D_RBEAT) ||
                    (state_nxt == D_RPOST); // R3 R4
         if (state_nxt == D_RPRE && state_r != D_RPRE) begin
            dqs_r <= '0;
         end else if (launch) begin
            dq_o_r <= rd_word; // R5 R12
            dqs_r <= ~dqs_r; // R5
         end
      end
   end

   assign link.data_lines_d = dq_o_r;
   assign link.data_lines_d_oe = dq_oe_r; // R3
   assign link.data_strobe_p_d = dqs_r;
   assign link.data_strobe_n_d = ~dqs_r;
   assign link.strobe_d_oe = dq_oe_r; // R4

   // ==========================================================
   // Byte lanes: storage, masked write, read and peek
   generate
      for (genvar i = 0; i < LANES; i++) begin : g_lane
         logic [LANE_W-1:0] mem_r [DEPTH];
         logic [BEAT_W-1:0] cnt_r;

         // Beats seen on this lane's own strobe
         always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
               cnt_r <= '0;
            end else if (state_r != D_WR) begin
               cnt_r <= '0;
            end else if (lane_edge[i] && !lane_done[i]) begin
               cnt_r <= cnt_r + 1'b1; // R6
            end
         end

         assign lane_done[i] = (cnt_r == BURST_CNT);

         // Store the byte unless its mask was high with the beat
         always_ff @(posedge clk) begin
            if (state_r == D_WR && lane_edge[i] && !lane_done[i] && !dm_s2[i]) begin // R7 R9
               mem_r[ADDR_W'(base_r + ADDR_W'(cnt_r))] <= dq_s2[i*LANE_W +: LANE_W]; // R6
            end
         end

         assign rd_word[i*LANE_W +: LANE_W] = mem_r[rd_idx];
         assign peek_word[i*LANE_W +: LANE_W] = mem_r[peek_addr];
      end
   endgenerate

   // ==========================================================
   // User-side status
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         peek_r <= '0;
         busy_r <= 1'b0;
      end else begin
         peek_r <= peek_word;
         busy_r <= (state_nxt != D_IDLE);
      end
   end

   assign peek_data = peek_r;
   assign cmd_seen = cmd_seen_r;
   assign cmd_op = op_r;
   assign cmd_addr = base_r;
   assign busy = busy_r;

endmodule : lpi_dev_end

// ### verilog/lpi_host_end.sv
// Host controller end: makes the link clock, issues commands, moves data.
// Assumes the device answers reads one link period after the command.
`timescale 1ns/1ps
module lpi_host_end (
   input wire logic clk,
   input wire logic rst_b,
   lpi_link_if.host link,
   input wire logic req_valid,
   output logic req_ready,
   input wire logic req_write,
   input wire logic [lpi_pkg::ADDR_W-1:0] req_addr,
   input wire logic wr_valid,
   output logic wr_ready,
   input wire logic [lpi_pkg::DQ_W-1:0] wr_data,
   input wire logic [lpi_pkg::LANES-1:0] wr_mask,
   output logic rd_valid,
   output logic [lpi_pkg::DQ_W-1:0] rd_data
);
   import lpi_pkg::*;

   typedef enum logic [5:0] {
      H_IDLE = 6'h01,
      H_CMD_HI = 6'h02,
      H_CMD_LO = 6'h04,
      H_WR = 6'h08,
      H_RD = 6'h10,
      H_TURN = 6'h20
   } lpi_hstate_type;

   lpi_hstate_type state_r;
   logic [PH_W-1:0] ph_r, ph_nxt;
   logic ck_r, launch, toggle, take, cs_r, wr_op_r, load, oe_r, full, empty, rd_valid_r;
   logic [CA_W-1:0] ca_r;
   logic [ADDR_W-1:0] addr_r;
   logic [BEAT_W-1:0] cnt_r;
   logic [TMR_W-1:0] tmr_r;
   logic [DQ_W-1:0] dq_r, dq_s1, dq_s2, rd_r;
   logic [LANES-1:0] dm_r, dqs_r, dqs_s1, dqs_s2, dqs_s3, lane_edge;
   logic [BUF_W-1:0] buf_r [BUF_DEPTH];
   logic [1:0] wp_r, rp_r;

   // ==========================================================
   // Link clock divider
   assign ph_nxt = PH_W'(ph_r + 1'b1);
   assign launch = (ph_r[1:0] == LAUNCH_PH);
   assign toggle = (ph_r[1:0] == TOGGLE_PH);
   assign req_ready = (state_r == H_IDLE) && launch && ph_r[CK_BIT];
   assign take = req_ready && req_valid;

   // Clock high for the first half of the phase grid
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ph_r <= '0;
         ck_r <= 1'b0;
      end else begin
         ph_r <= ph_nxt;
         ck_r <= ~ph_nxt[CK_BIT];
      end
   end

   // ==========================================================
   // Two-entry write buffer
   assign full = (wp_r[1] != rp_r[1]) && (wp_r[0] == rp_r[0]);
   assign empty = (wp_r == rp_r);
   assign wr_ready = ~full;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wp_r <= '0;
         rp_r <= '0;
      end else begin
         if (wr_valid && !full) begin
            wp_r <= wp_r + 1'b1;
         end
         if (load && !empty) begin
            rp_r <= rp_r + 1'b1;
         end
      end
   end

   // Entry storage
   always_ff @(posedge clk) begin
      if (wr_valid && !full) begin
         buf_r[wp_r[0]] <= {wr_mask, wr_data};
      end
   end

   // ==========================================================
   // Sequencer
   assign load = ((state_r == H_CMD_LO) && launch && wr_op_r) ||
                 ((state_r == H_WR) && launch && cnt_r != BURST_CNT);

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_r <= H_IDLE;
         wr_op_r <= 1'b0;
         addr_r <= '0;
         tmr_r <= '0;
      end else begin
         case (state_r)
            H_IDLE: begin
               if (take) begin
                  state_r <= H_CMD_HI;
                  wr_op_r <= req_write;
                  addr_r <= req_addr;
               end
            end
            H_CMD_HI: begin
               if (launch) begin
                  state_r <= H_CMD_LO;
               end
            end
            H_CMD_LO: begin
               if (launch) begin
                  state_r <= wr_op_r ? H_WR : H_RD;
               end
            end
            H_WR: begin
               if (launch && cnt_r == BURST_CNT) begin
                  state_r <= H_IDLE;
               end
            end
            H_RD: begin
               if (cnt_r == BURST_CNT) begin
                  state_r <= H_TURN;
                  tmr_r <= TMR_W'(TURN_CYC - 1);
               end
            end
            H_TURN: begin
               if (tmr_r == '0) begin
                  state_r <= H_IDLE;
               end else begin
                  tmr_r <= tmr_r - 1'b1;
               end
            end
            default: begin
               state_r <= H_IDLE;
            end
         endcase
      end
   end

   // Command pins: op with chip select, then address half a cycle later
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cs_r <= 1'b1;
         ca_r <= '0;
      end else if (take) begin
         cs_r <= 1'b0; // R1
         ca_r <= '0;
         ca_r[OP_LSB +: OP_W] <= req_write ? OP_WRITE : OP_READ; // R11
      end else if (state_r == H_CMD_HI && launch) begin
         cs_r <= 1'b1;
         ca_r <= '0;
         ca_r[ADDR_LSB +: ADDR_W] <= addr_r; // R11
      end else if (state_r == H_CMD_LO && launch) begin
         ca_r <= '0;
      end
   end

   // Beat and edge counter, write toggles or read edges
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_r <= '0;
      end else if (state_r != H_WR && state_r != H_RD) begin
         cnt_r <= '0;
      end else if (state_r == H_WR && toggle && cnt_r != BURST_CNT) begin
         cnt_r <= cnt_r + 1'b1;
      end else if (state_r == H_RD && lane_edge[0]) begin
         cnt_r <= cnt_r + 1'b1;
      end
   end

   // ==========================================================
   // Write drive: data at launch, strobe edge two cycles later
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         dq_r <= '0;
         dm_r <= '0;
         oe_r <= 1'b0;
         dqs_r <= '0;
      end else begin
         if (state_r == H_CMD_LO && launch && wr_op_r) begin
            oe_r <= 1'b1; // R3 R4
            dqs_r <= '0;
         end else if (state_r == H_WR && launch && cnt_r == BURST_CNT) begin
            oe_r <= 1'b0; // R13
         end
         if (load) begin
            dq_r <= empty ? '0 : buf_r[rp_r[0]][DQ_W-1:0];
            dm_r <= empty ? '1 : buf_r[rp_r[0]][BUF_W-1:DQ_W]; // R7 R9
         end
         if (state_r == H_WR && toggle && cnt_r != BURST_CNT) begin
            dqs_r <= ~dqs_r; // R5 R8
         end
      end
   end

   assign link.link_ck = ck_r;
   assign link.chip_sel_b = cs_r;
   assign link.cmd_addr_bus = ca_r; // R2
   assign link.write_byte_mask = dm_r;
   assign link.data_lines_h = dq_r;
   assign link.data_lines_h_oe = oe_r; // R13
   assign link.data_strobe_p_h = dqs_r;
   assign link.data_strobe_n_h = ~dqs_r;
   assign link.strobe_h_oe = oe_r; // R13

   // ==========================================================
   // Read capture on each lane's own strobe
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         dq_s1 <= '0;
         dq_s2 <= '0;
         dqs_s1 <= '0;
         dqs_s2 <= '0;
         dqs_s3 <= '0;
      end else begin
         dq_s1 <= link.data_lines;
         dq_s2 <= dq_s1;
         dqs_s1 <= link.data_strobe_p;
         dqs_s2 <= dqs_s1;
         dqs_s3 <= dqs_s2;
      end
   end

   assign lane_edge = dqs_s2 ^ dqs_s3;

   generate
      for (genvar i = 0; i < LANES; i++) begin : g_lane
         always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
               rd_r[i*LANE_W +: LANE_W] <= '0;
            end else if (state_r == H_RD && lane_edge[i]) begin
               rd_r[i*LANE_W +: LANE_W] <= dq_s2[i*LANE_W +: LANE_W]; // R5 R6
            end
         end
      end
   endgenerate

   // One pulse per read beat
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rd_valid_r <= 1'b0;
      end else begin
         rd_valid_r <= (state_r == H_RD) && lane_edge[0];
      end
   end

   assign rd_valid = rd_valid_r;
   assign rd_data = rd_r;

endmodule : lpi_host_end

// ### verilog/lpi_link_if.sv
// Link wires between host controller and memory device.
// Assumes the bench joins both modports; undriven lines read low, except data_strobe_n, which reads high.
`timescale 1ns/1ps
interface lpi_link_if;
   import lpi_pkg::*;

   logic link_ck;
   logic chip_sel_b;
   logic [CA_W-1:0] cmd_addr_bus;
   logic [LANES-1:0] write_byte_mask;
   logic [DQ_W-1:0] data_lines_h;
   logic data_lines_h_oe;
   logic [DQ_W-1:0] data_lines_d;
   logic data_lines_d_oe;
   logic [DQ_W-1:0] data_lines;
   logic [LANES-1:0] data_strobe_p_h;
   logic [LANES-1:0] data_strobe_n_h;
   logic strobe_h_oe;
   logic [LANES-1:0] data_strobe_p_d;
   logic [LANES-1:0] data_strobe_n_d;
   logic strobe_d_oe;
   logic [LANES-1:0] data_strobe_p;
   logic [LANES-1:0] data_strobe_n;

   // ==========================================================
   // Wire levels from the enables
   assign data_lines = data_lines_d_oe ? data_lines_d :
                       (data_lines_h_oe ? data_lines_h : '0);
   assign data_strobe_p = strobe_d_oe ? data_strobe_p_d :
                          (strobe_h_oe ? data_strobe_p_h : '0);
   assign data_strobe_n = strobe_d_oe ? data_strobe_n_d :
                          (strobe_h_oe ? data_strobe_n_h : '1);

   modport host (
      output link_ck, chip_sel_b, cmd_addr_bus, write_byte_mask,
      output data_lines_h, data_lines_h_oe, data_strobe_p_h, data_strobe_n_h, strobe_h_oe,
      input data_lines, data_strobe_p, data_strobe_n
   );

   modport device (
      input link_ck, chip_sel_b, cmd_addr_bus, write_byte_mask,
      input data_lines, data_strobe_p, data_strobe_n,
      output data_lines_d, data_lines_d_oe, data_strobe_p_d, data_strobe_n_d, strobe_d_oe
   );

endinterface : lpi_link_if

// ### verilog/lpi_pkg.sv
// Shared constants for both ends of the DDR pin-level link.
// Assumes one 50 MHz system clock at each end and a link clock of 160 ns.
package lpi_pkg;

   // ==========================================================
   // Widths
   localparam int CA_W = 10, DQ_W = 32, LANES = 4, LANE_W = 8, ADDR_W = 4;
   localparam int DEPTH = 16, OP_W = 2, BEAT_W = 3, TMR_W = 5, PH_W = 3;

   // ==========================================================
   // Timing, in ns and derived clock cycles
   localparam int CLK_PERIOD_NS = 20;
   localparam int LINK_PERIOD_NS = 160;
   localparam int CK_HALF_CYC = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);
   localparam int RD_GAP_CYC = 2 * CK_HALF_CYC;
   localparam int TURN_CYC = 2 * CK_HALF_CYC;

   // ==========================================================
   // Link phase grid (host divider)
   localparam int CK_BIT = 2;
   localparam logic [1:0] LAUNCH_PH = 2'h1;
   localparam logic [1:0] TOGGLE_PH = 2'h3;

   // ==========================================================
   // Command fields and codes
   localparam int OP_LSB = 0;
   localparam int ADDR_LSB = 0;
   localparam logic [OP_W-1:0] OP_WRITE = 2'h1;
   localparam logic [OP_W-1:0] OP_READ = 2'h2;
   localparam logic [BEAT_W-1:0] BURST_CNT = 3'h4;
   localparam logic [1:0] BEAT_LAST = 2'h3;

   // ==========================================================
   // Host write buffer
   localparam int BUF_DEPTH = 2;
   localparam int BUF_W = DQ_W + LANES;

endpackage : lpi_pkg
